// File: core/cc_control_regs.sv
// Register bank for CC attach status and general control.
// Assumes a byte register port from an I2C slave on core_clk.
`timescale 1ns/100ps
`default_nettype none
module cc_control_regs
   import cc_regs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   input  wire logic       i2c_mode_pin,
   input  wire logic [1:0] role_pins,
   input  wire cc_status_t cc_status,
   output logic            int_n,
   output logic            logic_reset,
   output logic            term_disable,
   output logic [1:0]      eff_role,
   output logic [1:0]      eff_try,
   output logic [1:0]      duty_code,
   output logic            accessory_off,
   output logic [31:0]     settle_cycles
);
   attach_status_t attach_reg, attach_next;
   gen_control_t   genctl_reg, genctl_next;
   logic [7:0]     rdata_reg, rdata_next;
   logic           int_n_reg, int_n_next;
   logic           srst_reg, srst_next;
   logic [2:0]     mode_sync_reg, mode_sync_next;
   logic [5:0]     pin_sync_reg, pin_sync_next;
   logic [1:0]     role_w, try_w;
   logic [31:0]    settle_w;
   logic [1:0]     role_o_reg, try_o_reg;
   logic [31:0]    settle_reg;
   logic           mode_stable_reg, mode_stable_next;
   logic [1:0]     pins_stable_reg, pins_stable_next;
   logic           changed;

   settle_time_sel u_settle (
      .code   (genctl_reg.cc_settle_time),
      .cycles (settle_w)
   );

   role_resolve u_role (
      .i2c_mode    (mode_stable_reg),
      .role_select (genctl_reg.role_select),
      .role_pins   (pins_stable_reg),
      .try_pref    (genctl_reg.role_try_preference),
      .role        (role_w),
      .try_mode    (try_w)
   );

   // Pins pass three stages; a change counts once stages two and three agree.
   always_comb begin
      mode_sync_next = {mode_sync_reg[1:0], i2c_mode_pin};
      pin_sync_next  = {pin_sync_reg[3:0], role_pins};
      mode_stable_next = mode_stable_reg;
      pins_stable_next = pins_stable_reg;
      if (mode_sync_reg[1] == mode_sync_reg[2]) begin
         mode_stable_next = mode_sync_reg[2];
      end
      if (pin_sync_reg[3:2] == pin_sync_reg[5:4]) begin
         pins_stable_next = pin_sync_reg[5:4];
      end
   end

   always_comb begin
      attach_next = attach_reg;
      genctl_next = genctl_reg;
      srst_next   = 1'b0;
      rdata_next  = rdata_reg;
      // Status follows the CC state machine; soft reset returns it to idle.
      if (srst_reg) begin
         attach_next.attach_result   = ATT_NONE;
         attach_next.orientation_cc1 = ATTACH_RESET[5];
      end else begin
         attach_next.attach_result   = cc_status.attach_result;
         attach_next.orientation_cc1 = cc_status.orientation_cc1;
      end
      if (cc_status.overcurrent) begin
         attach_next.plug_power_overcurrent_flag = 1'b1;
      end
      if (reg_write && reg_addr == ATTACH_REG_ADDR) begin
         attach_next.source_advertise_ratio = reg_wdata[2:1];
         attach_next.sink_accessory_disable = reg_wdata[0];
         if (reg_wdata[CHANGE_FLAG_BIT]) begin
            attach_next.change_flag = 1'b0;
         end
      end else if (reg_write && reg_addr == GENCTL_REG_ADDR) begin
         genctl_next.cc_settle_time      = reg_wdata[7:6];
         genctl_next.role_try_preference = reg_wdata[2:1];
         genctl_next.termination_disable = reg_wdata[0];
         // Role is locked while a partner is attached.
         if (attach_reg.attach_result == ATT_NONE) begin
            genctl_next.role_select = reg_wdata[5:4];
         end
         srst_next = reg_wdata[SOFT_RESET_BIT];
      end
      genctl_next.soft_reset = 1'b0;
      changed = (attach_next.attach_result != attach_reg.attach_result) ||
                (attach_next.orientation_cc1 != attach_reg.orientation_cc1) ||
                (attach_next.plug_power_overcurrent_flag !=
                 attach_reg.plug_power_overcurrent_flag) ||
                (attach_next.source_advertise_ratio !=
                 attach_reg.source_advertise_ratio) ||
                (attach_next.sink_accessory_disable !=
                 attach_reg.sink_accessory_disable) ||
                (genctl_next != genctl_reg);
      // A new change beats a clear in the same cycle.
      if (changed) begin
         attach_next.change_flag = 1'b1;
      end
      int_n_next = ~attach_next.change_flag;
      if (reg_read) begin
         if (reg_addr == ATTACH_REG_ADDR) begin
            rdata_next = attach_reg;
         end else if (reg_addr == GENCTL_REG_ADDR) begin
            rdata_next = genctl_reg;
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         attach_reg       <= ATTACH_RESET;
         genctl_reg       <= GENCTL_RESET;
         rdata_reg        <= 8'h00;
         int_n_reg        <= 1'b1;
         srst_reg         <= 1'b0;
         mode_sync_reg    <= 3'h0;
         pin_sync_reg     <= 6'h00;
         mode_stable_reg  <= 1'b0;
         pins_stable_reg  <= 2'h0;
         role_o_reg       <= 2'h0;
         try_o_reg        <= 2'h0;
         settle_reg       <= 32'h0;
      end else begin
         attach_reg       <= attach_next;
         genctl_reg       <= genctl_next;
         rdata_reg        <= rdata_next;
         int_n_reg        <= int_n_next;
         srst_reg         <= srst_next;
         mode_sync_reg    <= mode_sync_next;
         pin_sync_reg     <= pin_sync_next;
         mode_stable_reg  <= mode_stable_next;
         pins_stable_reg  <= pins_stable_next;
         role_o_reg       <= role_w;
         try_o_reg        <= try_w;
         settle_reg       <= settle_w;
      end
   end

   assign reg_rdata     = rdata_reg;
   assign int_n         = int_n_reg;
   assign logic_reset   = srst_reg;
   assign term_disable  = genctl_reg.termination_disable;
   assign eff_role      = role_o_reg;
   assign eff_try       = try_o_reg;
   assign duty_code     = attach_reg.source_advertise_ratio;
   assign accessory_off = attach_reg.sink_accessory_disable;
   assign settle_cycles = settle_reg;

   int_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      !int_n |-> attach_reg.change_flag)
      else $error("interrupt low while change flag clear");
   flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      attach_reg.change_flag && !(reg_write && reg_addr == ATTACH_REG_ADDR)
      |=> attach_reg.change_flag)
      else $error("change flag dropped without a clear");
   fault_set_a: assert property (@(posedge core_clk) disable iff (rst)
      cc_status.overcurrent
      |=> attach_reg.plug_power_overcurrent_flag)
      else $error("overcurrent not flagged");
   srst_self_a: assert property (@(posedge core_clk) disable iff (rst)
      srst_reg |=> !srst_reg)
      else $error("soft reset did not self clear");
   role_lock_a: assert property (@(posedge core_clk) disable iff (rst)
      attach_reg.attach_result != ATT_NONE
      |=> genctl_reg.role_select == $past(genctl_reg.role_select))
      else $error("role changed while attached");
   srst_att_a: assert property (@(posedge core_clk) disable iff (rst)
      srst_reg |=> attach_reg.attach_result == ATT_NONE)
      else $error("attach result not idle after soft reset");
   ratio_wr_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == ATTACH_REG_ADDR
      |=> attach_reg.source_advertise_ratio ==
          $past(reg_wdata[2:1]))
      else $error("advertise ratio not stored");
   // The interrupt pin is registered beside the flag, so both move together.
   change_int_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == GENCTL_REG_ADDR &&
      reg_wdata[0] != genctl_reg.termination_disable
      |=> !int_n)
      else $error("control change did not raise interrupt");

   // Status mirrors the CC state machine one cycle late unless reset.
   attach_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      !srst_reg
      |=> attach_reg.attach_result == $past(cc_status.attach_result))
      else $error("attach result does not follow the state machine");

   orient_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      !srst_reg
      |=> attach_reg.orientation_cc1 ==
          $past(cc_status.orientation_cc1))
      else $error("orientation does not follow the state machine");

   acc_store_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == ATTACH_REG_ADDR
      |=> attach_reg.sink_accessory_disable == $past(reg_wdata[0]))
      else $error("accessory disable not stored");

   // Only one code is checked here; the bench walks all four.
   settle_map_a: assert property (@(posedge core_clk) disable iff (rst)
      genctl_reg.cc_settle_time == 2'h1
      |=> settle_reg == 32'(SETTLE_118_MS * CYC_PER_MS))
      else $error("settle count wrong for code one");

   role_pin_a: assert property (@(posedge core_clk) disable iff (rst)
      !mode_stable_reg
      |=> role_o_reg == $past(pins_stable_reg))
      else $error("pin strap mode ignores role pins");

   role_field_a: assert property (@(posedge core_clk) disable iff (rst)
      mode_stable_reg && (genctl_reg.role_select == ROLE_UFP ||
                          genctl_reg.role_select == ROLE_DFP)
      |=> role_o_reg == $past(genctl_reg.role_select))
      else $error("role field not applied in I2C mode");

   try_off_a: assert property (@(posedge core_clk) disable iff (rst)
      role_w != ROLE_DRP
      |=> try_o_reg == PREF_STD)
      else $error("try preference active outside DRP");

   flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == ATTACH_REG_ADDR &&
      reg_wdata[CHANGE_FLAG_BIT] && !changed
      |=> !attach_reg.change_flag)
      else $error("change flag not cleared by write");

   flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
      changed |=> attach_reg.change_flag)
      else $error("register change did not set the flag");

   srst_start_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == GENCTL_REG_ADDR &&
      reg_wdata[SOFT_RESET_BIT]
      |=> srst_reg)
      else $error("soft reset write did not start a reset");

   term_store_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == GENCTL_REG_ADDR
      |=> term_disable == $past(reg_wdata[0]))
      else $error("termination disable not stored");
endmodule
`default_nettype wire

// File: core/cc_regs_pkg.sv
// Package for the CC status and control register bank.
// Assumes one 20 MHz clock and a byte-wide register port.
package cc_regs_pkg;
   localparam logic [7:0] ATTACH_REG_ADDR  = 8'h09;
   localparam logic [7:0] GENCTL_REG_ADDR  = 8'h0a;
   localparam logic [7:0] ATTACH_RESET     = 8'h20;
   localparam logic [7:0] GENCTL_RESET     = 8'h00;
   localparam int         CHANGE_FLAG_BIT  = 4;
   localparam int         SOFT_RESET_BIT   = 3;
   localparam int         CLK_HZ           = 20000000;
   localparam int         SETTLE_168_MS    = 168;
   localparam int         SETTLE_118_MS    = 118;
   localparam int         SETTLE_134_MS    = 134;
   localparam int         SETTLE_152_MS    = 152;
   localparam int         CYC_PER_MS       = CLK_HZ / 1000;
   localparam logic [1:0] ROLE_DRP         = 2'h0;
   localparam logic [1:0] ROLE_UFP         = 2'h1;
   localparam logic [1:0] ROLE_DFP         = 2'h2;
   localparam logic [1:0] PREF_STD         = 2'h0;
   localparam logic [1:0] PREF_TRY_SNK     = 2'h1;
   localparam logic [1:0] PREF_TRY_SRC     = 2'h3;
   localparam logic [1:0] ATT_NONE         = 2'h0;

   typedef struct packed {
      logic [1:0] attach_result;
      logic       orientation_cc1;
      logic       change_flag;
      logic       plug_power_overcurrent_flag;
      logic [1:0] source_advertise_ratio;
      logic       sink_accessory_disable;
   } attach_status_t;

   typedef struct packed {
      logic [1:0] cc_settle_time;
      logic [1:0] role_select;
      logic       soft_reset;
      logic [1:0] role_try_preference;
      logic       termination_disable;
   } gen_control_t;

   typedef struct packed {
      logic [1:0] attach_result;
      logic       orientation_cc1;
      logic       overcurrent;
   } cc_status_t;
endpackage

// File: core/settle_time_sel.sv
// Converts the CC settle time code into a cycle count.
// Assumes the package clock rate.
`timescale 1ns/100ps
`default_nettype none
module settle_time_sel
   import cc_regs_pkg::*;
(
   input  wire logic [1:0]  code,
   output logic      [31:0] cycles
);
   always_comb begin
      case (code)
         2'h1:    cycles = SETTLE_118_MS * CYC_PER_MS;
         2'h2:    cycles = SETTLE_134_MS * CYC_PER_MS;
         2'h3:    cycles = SETTLE_152_MS * CYC_PER_MS;
         default: cycles = SETTLE_168_MS * CYC_PER_MS;
      endcase
   end
endmodule
`default_nettype wire

// File: core/role_resolve.sv
// Resolves the effective port role from register fields and role pins.
// Assumes the pin levels are already synchronised.
`timescale 1ns/100ps
`default_nettype none
module role_resolve
   import cc_regs_pkg::*;
(
   input  wire logic       i2c_mode,
   input  wire logic [1:0] role_select,
   input  wire logic [1:0] role_pins,
   input  wire logic [1:0] try_pref,
   output logic      [1:0] role,
   output logic      [1:0] try_mode
);
   always_comb begin
      // Default field or pin strap mode hands control to the pins.
      if (i2c_mode && role_select != ROLE_DRP) begin
         role = (role_select == ROLE_UFP || role_select == ROLE_DFP)
                ? role_select : ROLE_DRP;
      end else begin
         role = role_pins;
      end
      if (role == ROLE_DRP && (try_pref == PREF_TRY_SNK ||
                               try_pref == PREF_TRY_SRC)) begin
         try_mode = try_pref;
      end else begin
         try_mode = PREF_STD;
      end
   end
endmodule
`default_nettype wire

// File: verif/cc_side_model.sv
// Model of the CC state machine that feeds attach status to the bank.
// Assumes the bench raises plug for one core_clk cycle per event.
`timescale 1ns/100ps
`default_nettype none
module cc_side_model
   import cc_regs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       logic_reset,
   input  wire logic       term_disable,
   input  wire logic       plug,
   input  wire logic [1:0] att_req,
   input  wire logic       ori_req,
   input  wire logic       fault_req,
   output var  cc_status_t cc_status
);
   always_ff @(posedge core_clk) begin
      cc_status.overcurrent <= fault_req;
      // A held or reset state machine forgets its partner.
      if (rst || logic_reset || term_disable) begin
         cc_status.attach_result   <= ATT_NONE;
         cc_status.orientation_cc1 <= 1'b1;
      end else if (plug) begin
         cc_status.attach_result   <= att_req;
         cc_status.orientation_cc1 <= ori_req;
      end
   end
endmodule
`default_nettype wire

// File: verif/typec_cc_status_control_regs_test.sv
// Self-checking bench for the CC status and control register bank.
// Assumes the byte register port and the CC side model beside it.
`timescale 1ns/100ps
`default_nettype none
module typec_cc_status_control_regs_test;
   import cc_regs_pkg::*;
   localparam int MS [4] = '{SETTLE_168_MS, SETTLE_118_MS,
                             SETTLE_134_MS, SETTLE_152_MS};
   localparam logic [1:0] TRYX [4] = '{PREF_STD, PREF_TRY_SNK,
                                       PREF_STD, PREF_TRY_SRC};
   // Pin mode, role pins, role field and expected role in one entry.
   localparam logic [6:0] RCASE [6] = '{7'h26, 7'h65, 7'h5a,
                                        7'h6c, 7'h62, 7'h40};
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic        i2c_mode_pin = 1'b1;
   logic [1:0]  role_pins = 2'h0;
   logic        plug = 1'b0;
   logic [1:0]  att_req = 2'h0;
   logic        ori_req = 1'b1;
   logic        fault_req = 1'b0;
   cc_status_t  cc_status;
   logic [7:0]  reg_rdata;
   logic        int_n;
   logic        logic_reset;
   logic        term_disable;
   logic [1:0]  eff_role;
   logic [1:0]  eff_try;
   logic [1:0]  duty_code;
   logic        accessory_off;
   logic [31:0] settle_cycles;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          n_pulse = 0;

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (logic_reset === 1'b1) n_pulse++;
   end

   cc_control_regs uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .i2c_mode_pin(i2c_mode_pin),
      .role_pins(role_pins), .cc_status(cc_status), .int_n(int_n),
      .logic_reset(logic_reset), .term_disable(term_disable),
      .eff_role(eff_role), .eff_try(eff_try), .duty_code(duty_code),
      .accessory_off(accessory_off), .settle_cycles(settle_cycles));
   cc_side_model cc_side (.core_clk(core_clk), .rst(rst),
      .logic_reset(logic_reset), .term_disable(term_disable), .plug(plug),
      .att_req(att_req), .ori_req(ori_req), .fault_req(fault_req),
      .cc_status(cc_status));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   // The byte is taken on one edge and compared once it has settled.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, exp);
   endtask
   task automatic plug_in(input logic [1:0] a, input logic o);
      @(posedge core_clk);
      att_req <= a;
      ori_req <= o;
      plug    <= 1'b1;
      @(posedge core_clk);
      plug    <= 1'b0;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      logic [6:0] c;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(ATTACH_REG_ADDR, ATTACH_RESET);
      rd(GENCTL_REG_ADDR, GENCTL_RESET);
      rd(8'h08, 8'h00);
      chk(int_n, 1'b1);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         wr(GENCTL_REG_ADDR, {i[1:0], 6'h00});
         settle(1);
         chk(settle_cycles, MS[i] * CYC_PER_MS);
      end
      chk(int_n, 1'b0);
      rd(ATTACH_REG_ADDR, 8'h30);
      wr(ATTACH_REG_ADDR, 8'h10);
      settle(1);
      chk(int_n, 1'b1);
      wr(ATTACH_REG_ADDR, 8'hd8);
      rd(ATTACH_REG_ADDR, 8'h20);
      done("flag");
      for (int i = 0; i < 4; i++) begin
         wr(ATTACH_REG_ADDR, {4'h1, 1'b0, i[1:0], ~i[0]});
         settle(1);
         chk(duty_code, i[1:0]);
         chk(accessory_off, 1'(~i[0]));
      end
      wr(ATTACH_REG_ADDR, 8'h16);
      rd(ATTACH_REG_ADDR, 8'h26);
      done("control");
      plug_in(2'h1, 1'b0);
      settle(2);
      rd(ATTACH_REG_ADDR, 8'h56);
      @(posedge core_clk);
      fault_req <= 1'b1;
      @(posedge core_clk);
      fault_req <= 1'b0;
      settle(3);
      rd(ATTACH_REG_ADDR, 8'h5e);
      wr(GENCTL_REG_ADDR, 8'hd0);
      rd(GENCTL_REG_ADDR, 8'hc0);
      wr(GENCTL_REG_ADDR, 8'hc8);
      settle(3);
      chk(n_pulse, 1);
      rd(GENCTL_REG_ADDR, 8'hc0);
      rd(ATTACH_REG_ADDR, 8'h3e);
      done("attach");
      for (int k = 0; k < 6; k++) begin
         c = RCASE[k];
         @(posedge core_clk);
         i2c_mode_pin <= c[6];
         role_pins    <= c[5:4];
         wr(GENCTL_REG_ADDR, {2'h3, c[3:2], 4'h0});
         settle(6);
         chk(eff_role, c[1:0]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(GENCTL_REG_ADDR, {5'h18, i[1:0], 1'b0});
         settle(2);
         chk(eff_try, TRYX[i]);
      end
      done("role");
      plug_in(2'h2, 1'b1);
      settle(2);
      rd(ATTACH_REG_ADDR, 8'hbe);
      wr(GENCTL_REG_ADDR, 8'hc1);
      settle(1);
      chk(term_disable, 1'b1);
      settle(2);
      rd(ATTACH_REG_ADDR, 8'h3e);
      rd(GENCTL_REG_ADDR, 8'hc1);
      done("termination");
      close_out();
   end
endmodule
`default_nettype wire
